/* cef_filter.sv */
// cef_filter.sv: type A card emulation command interpreter and anticollision filter
// ==========================================================
`timescale 1ns/1ns
module cef_filter (
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  cef_pkg::cef_byte_t  HOST_RX,
    output cef_pkg::cef_byte_t  HOST_TX,
    input  wire logic          LISTEN_ENTER,
    output logic               LISTEN_MODE,
    input  cef_pkg::cef_frame_t RDR_RX,
    output cef_pkg::cef_byte_t  RDR_TX,
    output cef_pkg::cef_frame_t RXB_WR,
    output logic               RXB_COMMIT,
    output logic               RXB_DROP,
    output logic               FILTER_ON,
    output logic [7:0]         CARD_STATE
);
    import cef_pkg::*;

    // ==========================================================
    // host command parser
    cef_hstate_t hs_r;
    logic [7:0]  len_r;
    logic [7:0]  cnt_r;
    logic [7:0]  eff_len;
    logic        echo;
    logic        cmd_done;
    logic        size_ok;
    logic        h_load;
    logic [2:0]  h_cnt;
    logic [39:0] h_bytes;

    assign echo     = (hs_r == HS_CODE) && HOST_RX.valid && (HOST_RX.data == CMD_ECHO);
    assign eff_len  = (hs_r == HS_LEN) ? HOST_RX.data : len_r;
    assign cmd_done = HOST_RX.valid && (((hs_r == HS_LEN) && (HOST_RX.data == LEN_OFF))
                      || ((hs_r == HS_DATA) && (cnt_r + 8'h01 == len_r)));
    assign size_ok  = (eff_len == LEN_CL1) || (eff_len == LEN_CL2)
                      || (eff_len == LEN_CL3);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            hs_r  <= HS_CODE;
            len_r <= 8'h00;
            cnt_r <= 8'h00;
        end else if (HOST_RX.valid) begin
            case (hs_r)
                HS_CODE: begin
                    if (HOST_RX.data == CMD_FILTER) begin
                        hs_r <= HS_LEN;
                    end
                end
                HS_LEN: begin
                    len_r <= HOST_RX.data;
                    cnt_r <= 8'h00;
                    hs_r  <= (HOST_RX.data == LEN_OFF) ? HS_CODE : HS_DATA;
                end
                HS_DATA: begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cmd_done) begin
                        hs_r <= HS_CODE;
                    end
                end
                default: hs_r <= HS_CODE;
            endcase
        end
    end

    // ==========================================================
    // filter configuration store
    logic       filter_r;
    logic [1:0] levels_r;
    logic [7:0] atqa0_r;
    logic [7:0] atqa1_r;
    logic [7:0] sak_r;
    logic [7:0] uid_r [UID_BYTES];
    logic       store;

    // payload only lands when the length is one of the activation sizes
    assign store = (hs_r == HS_DATA) && HOST_RX.valid && size_ok;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            filter_r <= 1'b0;
            levels_r <= 2'h1;
            atqa0_r  <= 8'h00;
            atqa1_r  <= 8'h00;
            sak_r    <= 8'h00;
        end else begin
            if (cmd_done && (eff_len == LEN_OFF)) begin
                filter_r <= 1'b0;
            end else if (cmd_done && size_ok) begin
                filter_r <= 1'b1;
                levels_r <= (eff_len == LEN_CL1) ? 2'h1 :
                            (eff_len == LEN_CL2) ? 2'h2 : 2'h3;
            end
            if (store && (cnt_r == OFS_ATQA0)) atqa0_r <= HOST_RX.data;
            if (store && (cnt_r == OFS_ATQA1)) atqa1_r <= HOST_RX.data;
            if (store && (cnt_r == OFS_SAK))   sak_r   <= HOST_RX.data;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < UID_BYTES; gi++) begin : g_uid
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    uid_r[gi] <= 8'h00;
                end else if (store && (cnt_r == OFS_UID + 8'(gi))) begin
                    uid_r[gi] <= HOST_RX.data;
                end
            end
        end
    endgenerate

    // ==========================================================
    // host answers and listen mode
    logic listen_r;

    always_comb begin
        h_load  = 1'b0;
        h_cnt   = 3'h0;
        h_bytes = '0;
        if (echo && listen_r) begin
            h_load  = 1'b1;
            h_cnt   = 3'h3;
            h_bytes = {16'h0000, LEN_NONE, ERR_LISTEN, CMD_ECHO};
        end else if (echo) begin
            h_load  = 1'b1;
            h_cnt   = 3'h1;
            h_bytes = {32'h0, CMD_ECHO};
        end else if (cmd_done) begin
            h_load = 1'b1;
            h_cnt  = 3'h2;
            if ((eff_len == LEN_OFF) || (eff_len == LEN_GET)) begin
                h_cnt   = 3'h3;
                h_bytes = {16'h0000, CARD_STATE, LEN_ONE, RES_OK};
            end else if ((eff_len == LEN_SET) || size_ok) begin
                h_bytes = {24'h0, LEN_NONE, RES_OK};
            end else begin
                h_bytes = {24'h0, LEN_NONE, ERR_BAD_LEN};
            end
        end
    end

    cef_byte_seq u_host_seq (
        .clk   (CLK),
        .reset (RESET),
        .load  (h_load),
        .count (h_cnt),
        .bytes (h_bytes),
        .tx    (HOST_TX)
    );

    // reader frames never touch listen mode, only host events do
    always_ff @(posedge CLK) begin
        if (RESET) begin
            listen_r <= 1'b0;
        end else if (LISTEN_ENTER) begin
            listen_r <= 1'b1;
        end else if (echo) begin
            listen_r <= 1'b0;
        end
    end

    // ==========================================================
    // reader frame capture, buffer path
    logic [7:0] frm_r [FRM_BYTES];
    logic [3:0] fcnt_r;
    logic [2:0] fbits_r;
    logic       fend_r;

    generate
        for (gi = 0; gi < FRM_BYTES; gi++) begin : g_frm
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    frm_r[gi] <= 8'h00;
                // a frame may start right behind the last one, before fcnt_r restarts
                end else if (RDR_RX.valid && ((fend_r ? 4'h0 : fcnt_r) == 4'(gi))) begin
                    frm_r[gi] <= RDR_RX.data;
                end
            end
        end
    endgenerate

    // bytes stream to the buffer at once; the frame end decides keep or drop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            fcnt_r  <= 4'h0;
            fbits_r <= 3'h0;
            fend_r  <= 1'b0;
            RXB_WR  <= '0;
        end else begin
            RXB_WR <= RDR_RX;
            fend_r <= RDR_RX.valid && RDR_RX.last;
            if (fend_r) begin
                fcnt_r <= RDR_RX.valid ? 4'h1 : 4'h0;
            end else if (RDR_RX.valid && (fcnt_r != FRM_MAX)) begin
                fcnt_r <= fcnt_r + 4'h1;
            end
            if (RDR_RX.valid) begin
                fbits_r <= RDR_RX.bits;
            end
        end
    end

    // ==========================================================
    // anticollision decode
    logic        is_sens, is_all, is_sdd, is_sel, is_slp, lvl_hit, interp;
    logic [1:0]  lvl;
    logic [3:0]  base;
    logic [31:0] part;
    logic [7:0]  bcc;
    logic        ready, active, uid_ok, last_lvl;

    assign is_sens  = (fcnt_r == FRM_SHORT) && (fbits_r == BITS_SHORT) && (frm_r[0] == RC_SENS);
    assign is_all   = (fcnt_r == FRM_SHORT) && (fbits_r == BITS_SHORT) && (frm_r[0] == RC_ALL);
    assign lvl      = (frm_r[0] == RC_CL1) ? 2'h0 : (frm_r[0] == RC_CL2) ? 2'h1 : 2'h2;
    assign lvl_hit  = ((frm_r[0] == RC_CL1) || (frm_r[0] == RC_CL2) || (frm_r[0] == RC_CL3))
                      && (lvl < levels_r);
    assign is_sdd   = lvl_hit && (fcnt_r == FRM_SDD);
    assign is_sel   = lvl_hit && (fcnt_r == FRM_SEL) && (frm_r[1] == RC_SEL_NVB);
    assign is_slp   = (fcnt_r == FRM_SDD) && (frm_r[0] == RC_SLP0) && (frm_r[1] == RC_SLP1);
    assign interp   = filter_r && (is_sens || is_all || is_sdd || is_sel || is_slp);
    assign base     = {lvl, 2'b00};
    assign part     = {uid_r[base + 4'h3], uid_r[base + 4'h2], uid_r[base + 4'h1], uid_r[base]};
    assign bcc      = part[7:0] ^ part[15:8] ^ part[23:16] ^ part[31:24];
    assign ready    = (CARD_STATE == ST_READY) || (CARD_STATE == ST_READY_H);
    assign active   = (CARD_STATE == ST_ACTIVE) || (CARD_STATE == ST_ACTIVE_H);
    assign uid_ok   = ({frm_r[5], frm_r[4], frm_r[3], frm_r[2]} == part) && (frm_r[6] == bcc);
    assign last_lvl = (lvl + 2'h1 == levels_r);

    logic        r_load;
    logic [2:0]  r_cnt;
    logic [39:0] r_bytes;
    logic        set_state;

    assign set_state = (hs_r == HS_DATA) && cmd_done && (len_r == LEN_SET);

    always_comb begin
        r_load  = 1'b0;
        r_cnt   = 3'h0;
        r_bytes = '0;
        if (fend_r && interp) begin
            if ((is_sens && (CARD_STATE == ST_IDLE)) || (is_all && !ready && !active)) begin
                r_load  = 1'b1;
                r_cnt   = 3'h2;
                r_bytes = {24'h0, atqa1_r, atqa0_r};
            end else if (is_sdd && ready) begin
                r_load  = 1'b1;
                r_cnt   = 3'h5;
                r_bytes = {bcc, part};
            end else if (is_sel && ready && uid_ok) begin
                r_load  = 1'b1;
                r_cnt   = 3'h1;
                r_bytes = {32'h0, last_lvl ? sak_r : (sak_r | SAK_CASCADE)};
            end
        end
    end

    cef_byte_seq u_rdr_seq (
        .clk   (CLK),
        .reset (RESET),
        .load  (r_load),
        .count (r_cnt),
        .bytes (r_bytes),
        .tx    (RDR_TX)
    );

    // host forcing outranks a reader transition in the same cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CARD_STATE <= ST_IDLE;
        end else if (set_state) begin
            CARD_STATE <= HOST_RX.data;
        end else if (fend_r && interp) begin
            if ((is_sens || is_all) && (CARD_STATE == ST_IDLE)) begin
                CARD_STATE <= ST_READY;
            end else if (is_all && (CARD_STATE == ST_HALT)) begin
                CARD_STATE <= ST_READY_H;
            end else if (is_sel && ready && uid_ok && last_lvl) begin
                CARD_STATE <= (CARD_STATE == ST_READY_H) ? ST_ACTIVE_H : ST_ACTIVE;
            end else if (is_slp && active) begin
                CARD_STATE <= ST_HALT;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            RXB_COMMIT <= 1'b0;
            RXB_DROP   <= 1'b0;
        end else begin
            RXB_COMMIT <= fend_r && !interp;
            RXB_DROP   <= fend_r && interp;
        end
    end

    assign LISTEN_MODE = listen_r;
    assign FILTER_ON   = filter_r;

    // ==========================================================
    // checks
    a_echo_plain: assert property (@(posedge CLK) disable iff (RESET)
        echo && !listen_r |=> ##1 HOST_TX.valid && HOST_TX.last && HOST_TX.data == CMD_ECHO)
        else $error("plain echo answer wrong");
    a_echo_listen: assert property (@(posedge CLK) disable iff (RESET)
        echo && listen_r |=> ##1 HOST_TX.data == CMD_ECHO ##1 HOST_TX.data == ERR_LISTEN
        ##1 HOST_TX.data == LEN_NONE && HOST_TX.last)
        else $error("listen echo answer wrong");
    a_listen_exit: assert property (@(posedge CLK) disable iff (RESET)
        echo && !LISTEN_ENTER |=> !LISTEN_MODE)
        else $error("echo did not end listen");
    a_bad_len: assert property (@(posedge CLK) disable iff (RESET)
        cmd_done && eff_len > LEN_GET && !size_ok |=> ##1 HOST_TX.data == ERR_BAD_LEN
        ##1 HOST_TX.data == LEN_NONE && HOST_TX.last)
        else $error("bad length not refused");
    a_filter_set: assert property (@(posedge CLK) disable iff (RESET)
        cmd_done && size_ok |=> FILTER_ON)
        else $error("filter not activated");
    a_filter_off: assert property (@(posedge CLK) disable iff (RESET)
        cmd_done && eff_len == LEN_OFF |=> !FILTER_ON ##1 HOST_TX.data == RES_OK)
        else $error("filter not deactivated");
    a_state_force: assert property (@(posedge CLK) disable iff (RESET)
        set_state |=> CARD_STATE == $past(HOST_RX.data))
        else $error("card state not forced");
    a_pass_off: assert property (@(posedge CLK) disable iff (RESET)
        fend_r && !FILTER_ON |=> RXB_COMMIT && !RXB_DROP)
        else $error("frame not committed");
    a_interp_drop: assert property (@(posedge CLK) disable iff (RESET)
        fend_r && interp |=> RXB_DROP && !RXB_COMMIT)
        else $error("interpreted frame reached buffer");
    a_sleep_halt: assert property (@(posedge CLK) disable iff (RESET)
        fend_r && interp && is_slp && active && !set_state |=> CARD_STATE == ST_HALT)
        else $error("sleep did not halt");
    a_sens_atqa: assert property (@(posedge CLK) disable iff (RESET)
        r_load && is_sens |=> ##1 RDR_TX.valid && RDR_TX.data == $past(atqa0_r, 2))
        else $error("sense answer wrong");

    c_echo_listen: cover property (@(posedge CLK) echo && listen_r);
    c_select_done: cover property (@(posedge CLK) fend_r && is_sel && r_load && last_lvl);
    c_sleep:       cover property (@(posedge CLK) fend_r && interp && is_slp && active);
    c_bad_len:     cover property (@(posedge CLK) cmd_done && !size_ok && eff_len > LEN_GET);

endmodule

/* cef_pkg.sv */
// cef_pkg.sv: constants, states and carriers of the card emulation filter
package cef_pkg;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } cef_byte_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [2:0] bits;
        logic [7:0] data;
    } cef_frame_t;

    typedef enum logic [2:0] {
        HS_CODE = 3'b001,
        HS_LEN  = 3'b010,
        HS_DATA = 3'b100
    } cef_hstate_t;

    // ==========================================================
    // host command codes, results and lengths
    localparam logic [7:0] CMD_FILTER  = 8'h0D;
    localparam logic [7:0] CMD_ECHO    = 8'h55;
    localparam logic [7:0] RES_OK      = 8'h00;
    localparam logic [7:0] ERR_BAD_LEN = 8'h82;
    localparam logic [7:0] ERR_LISTEN  = 8'h85;
    localparam logic [7:0] LEN_NONE    = 8'h00;
    localparam logic [7:0] LEN_ONE     = 8'h01;
    localparam logic [7:0] LEN_OFF     = 8'h00;
    localparam logic [7:0] LEN_SET     = 8'h01;
    localparam logic [7:0] LEN_GET     = 8'h02;
    localparam logic [7:0] LEN_CL1     = 8'h07;
    localparam logic [7:0] LEN_CL2     = 8'h0B;
    localparam logic [7:0] LEN_CL3     = 8'h0F;
    localparam logic [7:0] OFS_ATQA0   = 8'h00;
    localparam logic [7:0] OFS_ATQA1   = 8'h01;
    localparam logic [7:0] OFS_SAK     = 8'h02;
    localparam logic [7:0] OFS_UID     = 8'h03;
    localparam int         UID_BYTES   = 12;
    localparam int         FRM_BYTES   = 7;

    // ==========================================================
    // card emulation states
    localparam logic [7:0] ST_IDLE     = 8'h00;
    localparam logic [7:0] ST_READY    = 8'h01;
    localparam logic [7:0] ST_ACTIVE   = 8'h04;
    localparam logic [7:0] ST_HALT     = 8'h80;
    localparam logic [7:0] ST_READY_H  = 8'h81;
    localparam logic [7:0] ST_ACTIVE_H = 8'h84;

    // ==========================================================
    // reader frame codes
    localparam logic [7:0] RC_SENS     = 8'h26;
    localparam logic [7:0] RC_ALL      = 8'h52;
    localparam logic [7:0] RC_CL1      = 8'h93;
    localparam logic [7:0] RC_CL2      = 8'h95;
    localparam logic [7:0] RC_CL3      = 8'h97;
    localparam logic [7:0] RC_SEL_NVB  = 8'h70;
    localparam logic [7:0] RC_SLP0     = 8'h50;
    localparam logic [7:0] RC_SLP1     = 8'h00;
    localparam logic [7:0] SAK_CASCADE = 8'h04;
    localparam logic [2:0] BITS_SHORT  = 3'h7;
    localparam logic [3:0] FRM_SHORT   = 4'h1;
    localparam logic [3:0] FRM_SDD     = 4'h2;
    localparam logic [3:0] FRM_SEL     = 4'h7;
    localparam logic [3:0] FRM_MAX     = 4'h8;

endpackage

/* cef_byte_seq.sv */
// cef_byte_seq.sv: plays out up to five loaded bytes, one per clock
`timescale 1ns/1ns
module cef_byte_seq (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         load,
    input  wire logic [2:0]   count,
    input  wire logic [39:0]  bytes,
    output cef_pkg::cef_byte_t tx
);
    import cef_pkg::*;

    logic [39:0] sh_r;
    logic [2:0]  left_r;

    // a new load cuts off any answer still playing
    always_ff @(posedge clk) begin
        if (reset) begin
            sh_r   <= '0;
            left_r <= 3'h0;
            tx     <= '0;
        end else if (load) begin
            sh_r   <= bytes;
            left_r <= count;
            tx     <= '0;
        end else if (left_r != 3'h0) begin
            tx.valid <= 1'b1;
            tx.last  <= (left_r == 3'h1);
            tx.data  <= sh_r[7:0];
            sh_r     <= {8'h00, sh_r[39:8]};
            left_r   <= left_r - 3'h1;
        end else begin
            tx <= '0;
        end
    end

endmodule

/* cef_reader_model.sv */
// cef_reader_model.sv: contactless reader that sends frames and records answers
`timescale 1ns/1ns
module cef_reader_model (
    input  wire logic         clk,
    input  cef_pkg::cef_byte_t rdr_tx,
    input  wire logic         commit,
    input  wire logic         drop,
    input  cef_pkg::cef_frame_t wr,
    output cef_pkg::cef_frame_t rdr_rx
);
    import cef_pkg::*;
    logic [1:0]  outcome;
    logic [39:0] got;
    int          cnt;
    int          wcnt;
    initial rdr_rx = '0;
    // ==========================================================
    // answer capture
    always @(posedge clk) begin
        if (rdr_tx.valid) begin
            got <= {got[31:0], rdr_tx.data};
            cnt <= cnt + 1;
        end
        if (wr.valid) begin
            wcnt <= wcnt + 1;
        end
        if (commit || drop) begin
            outcome <= {drop, commit};
        end
    end
    // ==========================================================
    // frame driver
    task automatic send(input logic [55:0] f, input int n, input logic [2:0] bt);
        logic [7:0] b;
        got = '0;
        cnt = 0;
        wcnt = 0;
        outcome = '0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            b = f[8*(n-1-i) +: 8];
            rdr_rx <= '{1'b1, i == n - 1, bt, b};
        end
        @(negedge clk);
        // idle line must not show the last byte
        rdr_rx <= '{1'b0, 1'b0, 3'h0, ~b};
    endtask
endmodule

/* testbench.sv */
// testbench.sv: self-checking bench of the card emulation filter
`timescale 1ns/1ns
module testbench;
    import cef_pkg::*;
    typedef struct {
        logic [87:0] c;
        int          n;
        logic [23:0] a;
        int          m;
    } cef_row_t;
    logic       clk;
    logic       reset;
    cef_byte_t  host_rx;
    cef_byte_t  host_tx;
    logic       listen_enter;
    logic       listen_mode;
    cef_frame_t rdr_rx;
    cef_frame_t rxb_wr;
    cef_byte_t  rdr_tx;
    logic       commit;
    logic       drop;
    logic       filter_on;
    logic [7:0] card_state;
    int         n_fail;
    int         n_tests;
    logic [23:0] ans;
    int         len;
    cef_row_t   rows [4];
    logic [7:0] sts [6];

    cef_filter cef_filter_i (.CLK(clk), .RESET(reset), .HOST_RX(host_rx),
        .HOST_TX(host_tx), .LISTEN_ENTER(listen_enter), .LISTEN_MODE(listen_mode),
        .RDR_RX(rdr_rx), .RDR_TX(rdr_tx), .RXB_WR(rxb_wr), .RXB_COMMIT(commit),
        .RXB_DROP(drop), .FILTER_ON(filter_on), .CARD_STATE(card_state));
    cef_reader_model reader_i (.clk(clk), .rdr_tx(rdr_tx), .commit(commit),
        .drop(drop), .wr(rxb_wr), .rdr_rx(rdr_rx));

    always #25 clk = ~clk;

    // ==========================================================
    // helpers
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hcmd(input logic [103:0] c, input int n, input logic [23:0] a, input int m);
        int k;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            host_rx <= '{1'b1, 1'b0, c[8*(n-1-i) +: 8]};
        end
        @(negedge clk);
        host_rx <= '0;
        ans = '0;
        len = 0;
        k = 0;
        while (host_tx.valid !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        if (k == 10) begin
            n_fail++;
            final_report();
        end
        // a fourth byte would be a fault, so stop collecting at four
        while (host_tx.valid === 1'b1 && len < 4) begin
            ans = {ans[15:0], host_tx.data};
            len++;
            @(negedge clk);
        end
        chk("host answer", a, ans);
        chk("host count", m, len);
    endtask
    task automatic rdr(input logic [55:0] f, input int n, input logic [2:0] bt, input int oc,
                       input logic [39:0] tx, input int m, input logic [7:0] st);
        reader_i.send(f, n, bt);
        repeat (8) @(negedge clk);
        chk("buffer outcome", oc, reader_i.outcome);
        chk("buffer bytes", n, reader_i.wcnt);
        chk("reader answer", tx, reader_i.got);
        chk("reader count", m, reader_i.cnt);
        chk("card state", st, card_state);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        host_rx = '0;
        listen_enter = 1'b0;
        n_fail = 0;
        n_tests = 0;
        rows = '{'{88'h55, 1, 24'h55, 1}, '{88'h0D03AABBCC, 5, 24'h8200, 2},
                 '{88'h0D0744000011223344, 9, 24'h0000, 2}, '{88'h0D0100, 3, 24'h0000, 2}};
        sts = '{ST_READY, ST_ACTIVE, ST_HALT, ST_READY_H, ST_ACTIVE_H, ST_IDLE};
        repeat (6) @(negedge clk);
        chk("reset filter", 0, filter_on);
        chk("reset state", ST_IDLE, card_state);
        chk("reset listen", 0, listen_mode);
        reset = 1'b0;
        $display("reset test done");
        foreach (rows[i]) begin
            hcmd(rows[i].c, rows[i].n, rows[i].a, rows[i].m);
        end
        chk("filter on", 1, filter_on);
        foreach (sts[i]) begin
            hcmd({8'h0D, 8'h01, sts[i]}, 3, 24'h0000, 2);
            chk("forced state", sts[i], card_state);
            hcmd({8'h0D, 8'h02, 16'h0000}, 4, {16'h0001, sts[i]}, 3);
        end
        $display("host command test done");
        @(negedge clk);
        listen_enter = 1'b1;
        @(negedge clk);
        listen_enter = 1'b0;
        rdr(56'h26, 1, 3'h7, 2, 40'h4400, 2, ST_READY);
        chk("listen kept", 1, listen_mode);
        rdr(56'h9320, 2, 3'h0, 2, 40'h1122334444, 5, ST_READY);
        rdr(56'h93701122334444, 7, 3'h0, 2, 40'h00, 1, ST_ACTIVE);
        rdr(56'h5000, 2, 3'h0, 2, 40'h0, 0, ST_HALT);
        rdr(56'h26, 1, 3'h7, 2, 40'h0, 0, ST_HALT);
        rdr(56'h52, 1, 3'h7, 2, 40'h4400, 2, ST_READY_H);
        rdr(56'h3004, 2, 3'h0, 1, 40'h0, 0, ST_READY_H);
        chk("listen kept", 1, listen_mode);
        $display("reader frame test done");
        hcmd(88'h55, 1, 24'h558500, 3);
        chk("listen left", 0, listen_mode);
        $display("listen echo test done");
        hcmd(88'h0D00, 2, {16'h0001, ST_READY_H}, 3);
        chk("filter off", 0, filter_on);
        rdr(56'h26, 1, 3'h7, 1, 40'h0, 0, ST_READY_H);
        $display("filter off test done");
        hcmd({8'h0D, 8'h0B, 8'h44, 8'h00, 8'h20, 64'h1122334455667788}, 13, 24'h0000, 2);
        hcmd({8'h0D, 8'h01, ST_READY}, 3, 24'h0000, 2);
        rdr(56'h93701122334444, 7, 3'h0, 2, 40'h24, 1, ST_READY);
        rdr(56'h9520, 2, 3'h0, 2, 40'h55667788CC, 5, ST_READY);
        rdr(56'h957055667788CC, 7, 3'h0, 2, 40'h20, 1, ST_ACTIVE);
        $display("two level test done");
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk("reset filter", 0, filter_on);
        chk("reset state", ST_IDLE, card_state);
        hcmd(88'h55, 1, 24'h55, 1);
        $display("mid-run reset test done");
        final_report();
    end
endmodule
